// >>> design/rdpc_pkg.sv
package rdpc_pkg;

   // Direct register offsets
   localparam logic [3:0] RD_WIDX  = 4'h0;
   localparam logic [3:0] RD_PDATA = 4'h1;
   localparam logic [3:0] RD_MASK  = 4'h2;
   localparam logic [3:0] RD_RIDX  = 4'h3;
   localparam logic [3:0] RD_CIDX  = 4'h4;
   localparam logic [3:0] RD_CDATA = 4'h5;
   localparam logic [3:0] RD_XDATA = 4'ha;
   localparam logic [3:0] RD_CRAM  = 4'hb;
   localparam logic [3:0] RD_XLO   = 4'hc;
   localparam logic [3:0] RD_XHI   = 4'hd;
   localparam logic [3:0] RD_YLO   = 4'he;
   localparam logic [3:0] RD_YHI   = 4'hf;

   // Indexed register indices
   localparam logic [7:0] IX_PCTL      = 8'h06;
   localparam logic [7:0] IX_FMT       = 8'h18;
   localparam logic [7:0] IX_OMODE     = 8'h19;
   localparam logic [7:0] IX_PAGE      = 8'h1c;
   localparam logic [7:0] IX_MISC      = 8'h1e;
   localparam logic [7:0] IX_DOT_FIRST = 8'h20;
   localparam logic [7:0] IX_DOT_LAST  = 8'h28;
   localparam logic [7:0] IX_DOT_STAT  = 8'h29;
   localparam logic [7:0] IX_MEM_FIRST = 8'h30;
   localparam logic [7:0] IX_MEM_LAST  = 8'h32;
   localparam logic [7:0] IX_MEM_STAT  = 8'h33;
   localparam logic [7:0] IX_KEY_FIRST = 8'h40;
   localparam logic [7:0] IX_KEY_LAST  = 8'h44;

   // Field positions
   localparam int MISC_WIDE_BIT = 1;
   localparam int PROG_EN_BIT   = 3;
   localparam int STAT_RUN_BIT  = 4;

   // Cursor modes in control bits 1:0
   localparam logic [1:0] CM_OFF   = 2'h0;
   localparam logic [1:0] CM_THREE = 2'h1;
   localparam logic [1:0] CM_COMPL = 2'h2;
   localparam logic [1:0] CM_WIN   = 2'h3;

   // Values after reset, and the cursor origin offset
   localparam logic [7:0]  MASK_RST   = 8'hff;
   localparam logic [7:0]  DOT_A_M    = 8'h1c;
   localparam logic [7:0]  DOT_A_N    = 8'h08;
   localparam logic [7:0]  DOT_A_P    = 8'h09;
   localparam logic [7:0]  DOT_B_M    = 8'h10;
   localparam logic [7:0]  DOT_B_N    = 8'h08;
   localparam logic [7:0]  DOT_B_P    = 8'h08;
   localparam logic [7:0]  DOT_C_WORD = 8'h00;
   localparam logic [7:0]  MEM_M      = 8'h1c;
   localparam logic [7:0]  MEM_N      = 8'h08;
   localparam logic [7:0]  MEM_P      = 8'h08;
   localparam logic [15:0] POS_OFFSET = 16'h0040;

   typedef enum logic [2:0] {
      PH_RED = 3'b001,
      PH_GRN = 3'b010,
      PH_BLU = 3'b100
   } rdpc_phase_e;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [3:0] addr;
      logic [7:0] wdata;
   } rdpc_bus_s;

   typedef struct packed {
      logic [7:0] m;
      logic [7:0] n;
      logic [2:0] p;
      logic       en;
   } rdpc_synth_s;

   typedef struct packed {
      logic [255:0][2:0][7:0] pal;
      logic [1023:0][7:0]     cram;
      logic [3:0][2:0][7:0]   ccol;
      logic [8:0][7:0]        dot;
      logic [2:0][7:0]        mem;
      logic [4:0][7:0]        key;
      logic [7:0]             widx;
      logic [7:0]             ridx;
      logic [7:0]             cidx;
      logic [7:0]             mask;
      logic [7:0]             pctl;
      logic [7:0]             fmt;
      logic [7:0]             omode;
      logic [7:0]             page;
      logic [7:0]             misc;
      logic [15:0]            pos_x;
      logic [15:0]            pos_y;
      logic [15:0]            org_x;
      logic [15:0]            org_y;
      rdpc_phase_e            wph;
      rdpc_phase_e            rph;
      rdpc_phase_e            cph;
      logic [7:0]             rdata;
      logic [23:0]            pal_rgb;
      logic [23:0]            cur_rgb;
      logic                   cur_show;
      rdpc_synth_s            dot_act;
      rdpc_synth_s            mem_act;
   } rdpc_state_s;

endpackage : rdpc_pkg

// >>> design/rdpc_regs.sv
`timescale 1ns/1ps
module rdpc_regs (
   input  wire logic                clk_i,
   input  wire logic                srst_i,
   input  wire rdpc_pkg::rdpc_bus_s bus_i,
   output logic [7:0]               rdata_o,
   input  wire logic [7:0]          pix_idx_i,
   input  wire logic                legacy_mode_i,
   input  wire logic [1:0]          vclk_sel_i,
   input  wire logic [1:0]          cur_planes_i,
   input  wire logic [23:0]         under_rgb_i,
   output logic [23:0]              pal_rgb_o,
   output logic [23:0]              cur_rgb_o,
   output logic                     cur_show_o,
   output logic [15:0]              cur_pos_x_o,
   output logic [15:0]              cur_pos_y_o,
   output logic [15:0]              cur_org_x_o,
   output logic [15:0]              cur_org_y_o,
   output rdpc_pkg::rdpc_synth_s    dot_synth_o,
   output rdpc_pkg::rdpc_synth_s    mem_synth_o
);
   import rdpc_pkg::*;

   rdpc_state_s st_r;
   rdpc_state_s st_nxt;

   // Component slot of a byte phase
   function automatic logic [1:0] ph_idx(input rdpc_phase_e ph);
      case (ph)
         PH_GRN:  ph_idx = 2'h1;
         PH_BLU:  ph_idx = 2'h2;
         default: ph_idx = 2'h0;
      endcase
   endfunction : ph_idx

   // Red, green, blue, then back to red
   function automatic rdpc_phase_e ph_next(input rdpc_phase_e ph);
      case (ph)
         PH_RED:  ph_next = PH_GRN;
         PH_GRN:  ph_next = PH_BLU;
         default: ph_next = PH_RED;
      endcase
   endfunction : ph_next

   // First program word of the chosen dot set; 3 also falls on set C
   function automatic logic [3:0] set_base(input logic [1:0] sel);
      case (sel)
         2'h0:    set_base = 4'h0;
         2'h1:    set_base = 4'h3;
         default: set_base = 4'h6;
      endcase
   endfunction : set_base

   // Everything the block does, one cycle at a time
   always_comb begin
      logic [9:0]  ca;
      logic [9:0]  ca_inc;
      logic [7:0]  comp;
      logic [7:0]  xi;
      logic [7:0]  xr;
      logic [7:0]  pix;
      logic [3:0]  sb;
      logic [23:0] c0;
      logic [23:0] c1;
      logic [23:0] c2;
      logic        wide;
      ca     = {st_r.pctl[3:2], st_r.widx};
      ca_inc = ca + 10'h001;
      comp   = 8'h00;
      xi     = st_r.widx;
      xr     = 8'h00;
      pix    = 8'h00;
      sb     = set_base(vclk_sel_i);
      c0     = {st_r.ccol[1][0], st_r.ccol[1][1], st_r.ccol[1][2]};
      c1     = {st_r.ccol[2][0], st_r.ccol[2][1], st_r.ccol[2][2]};
      c2     = {st_r.ccol[3][0], st_r.ccol[3][1], st_r.ccol[3][2]};
      wide   = st_r.misc[MISC_WIDE_BIT];
      st_nxt = st_r;

      // Indexed read mux; program words read zero, status shows state
      if (xi == IX_PCTL) begin
         xr = st_r.pctl;
      end else if (xi == IX_FMT) begin
         xr = st_r.fmt;
      end else if (xi == IX_OMODE) begin
         xr = st_r.omode;
      end else if (xi == IX_PAGE) begin
         xr = st_r.page;
      end else if (xi == IX_MISC) begin
         xr = st_r.misc;
      end else if (xi == IX_DOT_STAT) begin
         xr = 8'h00;
         xr[STAT_RUN_BIT] = st_r.dot_act.en;
      end else if (xi == IX_MEM_STAT) begin
         xr = 8'h00;
         xr[STAT_RUN_BIT] = st_r.mem_act.en;
      end else if (xi >= IX_KEY_FIRST && xi <= IX_KEY_LAST) begin
         xr = st_r.key[3'(xi - IX_KEY_FIRST)];
      end

      // Host writes take precedence over a read in the same cycle
      if (bus_i.we) begin
         case (bus_i.addr)
            RD_WIDX: begin
               st_nxt.widx = bus_i.wdata;
               st_nxt.wph  = PH_RED;
            end
            RD_PDATA: begin
               if (wide) begin
                  st_nxt.pal[st_r.widx][ph_idx(st_r.wph)] = bus_i.wdata;
               end else begin
                  st_nxt.pal[st_r.widx][ph_idx(st_r.wph)] =
                     {bus_i.wdata[5:0], 2'h0};
               end
               st_nxt.wph = ph_next(st_r.wph);
               if (st_r.wph == PH_BLU) begin
                  st_nxt.widx = st_r.widx + 8'h01;
               end
            end
            RD_MASK: st_nxt.mask = bus_i.wdata;
            RD_RIDX: begin
               st_nxt.ridx = bus_i.wdata;
               st_nxt.rph  = PH_RED;
            end
            RD_CIDX: begin
               st_nxt.cidx = bus_i.wdata;
               st_nxt.cph  = PH_RED;
            end
            RD_CDATA: begin
               st_nxt.ccol[st_r.cidx[1:0]][ph_idx(st_r.cph)] =
                  bus_i.wdata;
               st_nxt.cph = ph_next(st_r.cph);
               if (st_r.cph == PH_BLU) begin
                  st_nxt.cidx = st_r.cidx + 8'h01;
               end
            end
            RD_XDATA: begin
               // Indexed write through the index held at 00h
               if (xi == IX_PCTL) begin
                  st_nxt.pctl = bus_i.wdata;
               end else if (xi == IX_FMT) begin
                  st_nxt.fmt = bus_i.wdata;
               end else if (xi == IX_OMODE) begin
                  st_nxt.omode = bus_i.wdata;
               end else if (xi == IX_PAGE) begin
                  st_nxt.page = bus_i.wdata;
               end else if (xi == IX_MISC) begin
                  st_nxt.misc = bus_i.wdata;
               end else if (xi >= IX_DOT_FIRST && xi <= IX_DOT_LAST) begin
                  st_nxt.dot[4'(xi - IX_DOT_FIRST)] = bus_i.wdata;
               end else if (xi >= IX_MEM_FIRST && xi <= IX_MEM_LAST) begin
                  st_nxt.mem[2'(xi - IX_MEM_FIRST)] = bus_i.wdata;
               end else if (xi >= IX_KEY_FIRST && xi <= IX_KEY_LAST) begin
                  st_nxt.key[3'(xi - IX_KEY_FIRST)] = bus_i.wdata;
               end
            end
            RD_CRAM: begin
               st_nxt.cram[ca] = bus_i.wdata;
               {st_nxt.pctl[3:2], st_nxt.widx} = ca_inc;
            end
            RD_XLO:  st_nxt.pos_x[7:0]  = bus_i.wdata;
            RD_XHI:  st_nxt.pos_x[15:8] = bus_i.wdata;
            RD_YLO:  st_nxt.pos_y[7:0]  = bus_i.wdata;
            RD_YHI:  st_nxt.pos_y[15:8] = bus_i.wdata;
            default: ;
         endcase
      end else if (bus_i.re) begin
         case (bus_i.addr)
            RD_WIDX: st_nxt.rdata = st_r.widx;
            RD_PDATA: begin
               comp = st_r.pal[st_r.ridx][ph_idx(st_r.rph)];
               st_nxt.rdata = wide ? comp : {2'h0, comp[7:2]};
               st_nxt.rph = ph_next(st_r.rph);
               if (st_r.rph == PH_BLU) begin
                  st_nxt.ridx = st_r.ridx + 8'h01;
               end
            end
            RD_MASK: st_nxt.rdata = st_r.mask;
            RD_RIDX: st_nxt.rdata = st_r.ridx;
            RD_CIDX: st_nxt.rdata = st_r.cidx;
            RD_CDATA: begin
               st_nxt.rdata = st_r.ccol[st_r.cidx[1:0]][ph_idx(st_r.cph)];
               st_nxt.cph = ph_next(st_r.cph);
               if (st_r.cph == PH_BLU) begin
                  st_nxt.cidx = st_r.cidx + 8'h01;
               end
            end
            RD_XDATA: st_nxt.rdata = xr;
            RD_CRAM: begin
               st_nxt.rdata = st_r.cram[ca];
               {st_nxt.pctl[3:2], st_nxt.widx} = ca_inc;
            end
            RD_XLO:  st_nxt.rdata = st_r.pos_x[7:0];
            RD_XHI:  st_nxt.rdata = st_r.pos_x[15:8];
            RD_YLO:  st_nxt.rdata = st_r.pos_y[7:0];
            RD_YHI:  st_nxt.rdata = st_r.pos_y[15:8];
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      // Pixel lookup; mask only gates planes in the legacy path
      pix = legacy_mode_i ? (pix_idx_i & st_r.mask) : pix_idx_i;
      pix = pix | st_r.page;
      st_nxt.pal_rgb = {st_r.pal[pix][0], st_r.pal[pix][1],
                        st_r.pal[pix][2]};

      // Cursor overlay; transparent passes the underlying pixel
      st_nxt.cur_show = 1'b1;
      st_nxt.cur_rgb  = under_rgb_i;
      case (st_r.pctl[1:0])
         CM_THREE: begin
            case (cur_planes_i)
               2'h1:    st_nxt.cur_rgb = c0;
               2'h2:    st_nxt.cur_rgb = c1;
               2'h3:    st_nxt.cur_rgb = c2;
               default: st_nxt.cur_show = 1'b0;
            endcase
         end
         CM_COMPL: begin
            case (cur_planes_i)
               2'h0:    st_nxt.cur_rgb = c0;
               2'h1:    st_nxt.cur_rgb = c1;
               2'h3:    st_nxt.cur_rgb = ~under_rgb_i;
               default: st_nxt.cur_show = 1'b0;
            endcase
         end
         CM_WIN: begin
            case (cur_planes_i)
               2'h2:    st_nxt.cur_rgb = c0;
               2'h3:    st_nxt.cur_rgb = c1;
               default: st_nxt.cur_show = 1'b0;
            endcase
         end
         default: st_nxt.cur_show = 1'b0;
      endcase

      // Corner to origin; wraps for positions under 64
      st_nxt.org_x = st_r.pos_x - POS_OFFSET;
      st_nxt.org_y = st_r.pos_y - POS_OFFSET;

      // Active synthesiser settings, M over N over two to the P
      st_nxt.dot_act.m  = st_r.dot[sb];
      st_nxt.dot_act.n  = st_r.dot[4'(sb + 4'h1)];
      st_nxt.dot_act.p  = st_r.dot[4'(sb + 4'h2)][2:0];
      st_nxt.dot_act.en = st_r.dot[4'(sb + 4'h2)][PROG_EN_BIT];
      st_nxt.mem_act.m  = st_r.mem[0];
      st_nxt.mem_act.n  = st_r.mem[1];
      st_nxt.mem_act.p  = st_r.mem[2][2:0];
      st_nxt.mem_act.en = st_r.mem[2][PROG_EN_BIT];

      // Synchronous reset; storage clears, synthesisers take defaults
      if (srst_i) begin
         st_nxt        = '0;
         st_nxt.mask   = MASK_RST;
         st_nxt.wph    = PH_RED;
         st_nxt.rph    = PH_RED;
         st_nxt.cph    = PH_RED;
         st_nxt.dot[0] = DOT_A_M;
         st_nxt.dot[1] = DOT_A_N;
         st_nxt.dot[2] = DOT_A_P;
         st_nxt.dot[3] = DOT_B_M;
         st_nxt.dot[4] = DOT_B_N;
         st_nxt.dot[5] = DOT_B_P;
         st_nxt.dot[6] = DOT_C_WORD;
         st_nxt.dot[7] = DOT_C_WORD;
         st_nxt.dot[8] = DOT_C_WORD;
         st_nxt.mem[0] = MEM_M;
         st_nxt.mem[1] = MEM_N;
         st_nxt.mem[2] = MEM_P;
      end
   end

   // Single state register
   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // Outputs straight from the state flops
   assign rdata_o     = st_r.rdata;
   assign pal_rgb_o   = st_r.pal_rgb;
   assign cur_rgb_o   = st_r.cur_rgb;
   assign cur_show_o  = st_r.cur_show;
   assign cur_pos_x_o = st_r.pos_x;
   assign cur_pos_y_o = st_r.pos_y;
   assign cur_org_x_o = st_r.org_x;
   assign cur_org_y_o = st_r.org_y;
   assign dot_synth_o = st_r.dot_act;
   assign mem_synth_o = st_r.mem_act;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   // Blue write moves the palette write index on by one
   a_pal_wr_adv: assert property (
      bus_i.we && bus_i.addr == RD_PDATA && st_r.wph == PH_BLU
      |=> st_r.widx == 8'($past(st_r.widx) + 8'h01) && st_r.wph == PH_RED)
      else $error("palette write index did not advance after blue");

   // Narrow mode stores the six written bits shifted up
   a_pal_six_wr: assert property (
      bus_i.we && bus_i.addr == RD_PDATA && !st_r.misc[MISC_WIDE_BIT]
      && st_r.wph == PH_RED
      |=> st_r.pal[$past(st_r.widx)][0] == {$past(bus_i.wdata[5:0]), 2'h0})
      else $error("six-bit palette write not shifted up");

   // Narrow mode reads return the top bits of the entry shifted down
   a_pal_six_rd: assert property (
      bus_i.re && !bus_i.we && bus_i.addr == RD_PDATA
      && !st_r.misc[MISC_WIDE_BIT]
      |=> rdata_o[7:6] == 2'h0)
      else $error("six-bit palette read has top bits set");

   // Three reads of one entry leave the read index one further
   a_pal_rd_adv: assert property (
      bus_i.re && !bus_i.we && bus_i.addr == RD_PDATA && st_r.rph == PH_BLU
      |=> st_r.ridx == 8'($past(st_r.ridx) + 8'h01))
      else $error("palette read index did not advance after blue");

   // Legacy lookup uses the masked index, then the page bits
   a_mask_and: assert property (
      legacy_mode_i
      |=> pal_rgb_o[23:16] ==
          $past(st_r.pal[(pix_idx_i & st_r.mask) | st_r.page][0])
      && pal_rgb_o[7:0] ==
          $past(st_r.pal[(pix_idx_i & st_r.mask) | st_r.page][2]))
      else $error("read mask not applied to pixel index");

   // Blue colour write advances the colour address
   a_ccol_adv: assert property (
      bus_i.we && bus_i.addr == RD_CDATA && st_r.cph == PH_BLU
      |=> st_r.cidx == 8'($past(st_r.cidx) + 8'h01))
      else $error("cursor colour address did not advance");

   // Cursor RAM access at the end of a page carries into control
   a_cram_carry: assert property (
      (bus_i.we || bus_i.re) && bus_i.addr == RD_CRAM && st_r.widx == 8'hff
      |=> st_r.widx == 8'h00
      && st_r.pctl[3:2] == 2'($past(st_r.pctl[3:2]) + 2'h1))
      else $error("cursor RAM address carry lost");

   // Program words never read back
   a_prog_wo: assert property (
      bus_i.re && !bus_i.we && bus_i.addr == RD_XDATA
      && st_r.widx >= IX_DOT_FIRST && st_r.widx <= IX_DOT_LAST
      |=> rdata_o == 8'h00)
      else $error("write-only program register read back data");

   // Writing an address restarts the byte phase
   a_phase_rst: assert property (
      bus_i.we && bus_i.addr == RD_CIDX |=> st_r.cph == PH_RED)
      else $error("colour phase not reset by address write");

   // Complement mode code three shows the inverted pixel
   a_cur_compl: assert property (
      st_r.pctl[1:0] == CM_COMPL && cur_planes_i == 2'h3
      |=> cur_rgb_o == ~$past(under_rgb_i) && cur_show_o)
      else $error("complement cursor colour wrong");

   // Cursor switched off always passes the underlying pixel
   a_cur_off: assert property (
      st_r.pctl[1:0] == CM_OFF
      |=> !cur_show_o && cur_rgb_o == $past(under_rgb_i))
      else $error("cursor shown while switched off");

   // Set B select hands its own program words to the synthesiser
   a_dot_sel_b: assert property (
      vclk_sel_i == 2'h1
      |=> dot_synth_o.m == $past(st_r.dot[3])
      && dot_synth_o.n == $past(st_r.dot[4]))
      else $error("dot synthesiser set select not followed");

   // Origin trails the corner by 64 on both axes, one cycle late
   a_org_offset: assert property (
      !srst_i
      |=> 16'(cur_org_x_o + POS_OFFSET) == $past(cur_pos_x_o)
      && 16'(cur_org_y_o + POS_OFFSET) == $past(cur_pos_y_o))
      else $error("cursor origin not offset by 64");

endmodule : rdpc_regs

// >>> testbench/tb.sv
`timescale 1ns/1ps
// Self-checking bench with a byte-level model of the register bank
module tb;
   import rdpc_pkg::*;

   // Design ports
   logic        clk_i         = 1'b0;
   logic        srst_i        = 1'b1;
   rdpc_bus_s   bus_i         = '0;
   logic [7:0]  pix_idx_i     = 8'h00;
   logic        legacy_mode_i = 1'b0;
   logic [1:0]  vclk_sel_i    = 2'h0;
   logic [1:0]  cur_planes_i  = 2'h0;
   logic [23:0] under_rgb_i   = 24'h000000;
   logic [7:0]  rdata_o;
   logic [23:0] pal_rgb_o, cur_rgb_o;
   logic        cur_show_o;
   logic [15:0] cur_pos_x_o, cur_pos_y_o, cur_org_x_o, cur_org_y_o;
   rdpc_synth_s dot_synth_o, mem_synth_o;
   // Model state; everything not written stays at its cleared value
   int          pal [256][3];
   int          ccol [4][3];
   int          cram [1024];
   logic [7:0]  exp_q [$];
   int          wide, failures, checks, cyc, i, k, m, t, seed;
   logic        rd_taken = 1'b0;
   logic [7:0]  v;
   logic [15:0] px, py;
   // Slot per plane code; -1 shows the pixel, -2 its complement
   // Last row is the cursor switched off
   int cur_t [4][4] = '{'{-1, 1, 2, 3}, '{1, 2, -1, -2},
                        '{-1, -1, 1, 2}, '{-1, -1, -1, -1}};

   rdpc_regs u_dut (
      .clk_i(clk_i), .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .pix_idx_i(pix_idx_i), .legacy_mode_i(legacy_mode_i),
      .vclk_sel_i(vclk_sel_i), .cur_planes_i(cur_planes_i),
      .under_rgb_i(under_rgb_i), .pal_rgb_o(pal_rgb_o),
      .cur_rgb_o(cur_rgb_o), .cur_show_o(cur_show_o),
      .cur_pos_x_o(cur_pos_x_o), .cur_pos_y_o(cur_pos_y_o),
      .cur_org_x_o(cur_org_x_o), .cur_org_y_o(cur_org_y_o),
      .dot_synth_o(dot_synth_o), .mem_synth_o(mem_synth_o)
   );

   always #50 clk_i = ~clk_i;

   // Palette packing as the model expects it in each width mode
   function automatic logic [7:0] sto(input logic [7:0] d);
      return (wide != 0) ? d : {d[5:0], 2'b00};
   endfunction : sto
   function automatic logic [7:0] ret(input logic [7:0] d);
      return (wide != 0) ? d : {2'b00, d[7:2]};
   endfunction : ret
   function automatic rdpc_synth_s syn(input logic [7:0] m1, n1, w3);
      return '{m: m1, n: n1, p: w3[2:0], en: w3[PROG_EN_BIT]};
   endfunction : syn

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One bus request per edge; the next call replaces it, so no gaps
   task automatic go(input logic we, re, input logic [3:0] a,
                     input logic [7:0] d);
      @(posedge clk_i);
      bus_i <= '{we: we, re: re, addr: a, wdata: d};
   endtask : go
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      go(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      go(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   task automatic ixw(input logic [7:0] x, input logic [7:0] d);
      wr(RD_WIDX, x);
      wr(RD_XDATA, d);
   endtask : ixw
   task automatic ixr(input logic [7:0] x, input logic [7:0] e);
      wr(RD_WIDX, x);
      rd(RD_XDATA, e);
   endtask : ixr
   // Two idle edges cover the registered outputs, then sample at the fall
   task automatic idle2;
      go(1'b0, 1'b0, 4'h0, 8'h00);
      go(1'b0, 1'b0, 4'h0, 8'h00);
      @(negedge clk_i);
   endtask : idle2
   task automatic pent(input int e);
      for (int c = 0; c < 3; c++) begin
         v = 8'($urandom);
         pal[e][c] = sto(v);
         wr(RD_PDATA, v);
      end
   endtask : pent
   task automatic prd(input int e, input int n);
      wr(RD_RIDX, 8'(e));
      for (int j = 0; j < n * 3; j++)
         rd(RD_PDATA, ret(8'(pal[(e + j / 3) % 256][j % 3])));
   endtask : prd
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Read data lands at the taking edge; compared half a cycle later
   always @(posedge clk_i) rd_taken <= bus_i.re & ~bus_i.we;
   always @(negedge clk_i) begin
      if (rd_taken === 1'b1) chk(32'(rdata_o), 32'(exp_q.pop_front()));
   end
   // Whole run is under a thousand cycles; five thousand means a hang
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         report_and_stop();
      end
   end

   initial begin
      seed = $urandom(54248);
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      // Defaults, access kinds and the synthesiser set select
      idle2();
      chk(32'(dot_synth_o), 32'(syn(DOT_A_M, DOT_A_N, DOT_A_P)));
      chk(32'(mem_synth_o), 32'(syn(MEM_M, MEM_N, MEM_P)));
      rd(RD_MASK, MASK_RST);
      rd(4'h6, 8'h00);
      ixr(IX_DOT_STAT, 8'h10);
      ixr(IX_DOT_FIRST, 8'h00);
      ixr(IX_MEM_STAT, 8'h10);
      ixw(IX_FMT, 8'ha5);
      ixr(IX_FMT, 8'ha5);
      ixw(IX_DOT_FIRST + 8'h02, 8'h02);
      for (i = 0; i < 4; i++) begin
         go(1'b0, 1'b0, 4'h0, 8'h00);
         vclk_sel_i <= 2'(i);
         idle2();
         chk(32'(dot_synth_o), 32'((i == 0) ? syn(DOT_A_M, DOT_A_N, 8'h02) :
             (i == 1) ? syn(DOT_B_M, DOT_B_N, DOT_B_P) :
             syn(DOT_C_WORD, DOT_C_WORD, DOT_C_WORD)));
      end
      ixr(IX_DOT_STAT, 8'h00);
      // Palette: wrap past the last entry, a restarted phase, 6-bit mode
      wide = 1;
      ixw(IX_MISC, 8'h02);
      wr(RD_WIDX, 8'hff);
      pent(255);
      pent(0);
      wide = 0;
      ixw(IX_MISC, 8'h00);
      wr(RD_WIDX, 8'h07);
      wr(RD_PDATA, 8'h3f);
      wr(RD_WIDX, 8'h07);
      pent(7);
      prd(255, 2);
      prd(7, 1);
      // Pixel lookup with and without the read mask
      wr(RD_MASK, 8'h07);
      for (i = 0; i < 3; i++) begin
         if (i == 2) ixw(IX_PAGE, 8'hf8);
         go(1'b0, 1'b0, 4'h0, 8'h00);
         legacy_mode_i <= (i != 1);
         pix_idx_i     <= 8'hff;
         idle2();
         t = (i == 0) ? 7 : 255;
         chk(32'(pal_rgb_o), {8'h00, 8'(pal[t][0]), 8'(pal[t][1]),
             8'(pal[t][2])});
      end
      // Cursor colours, starting at slot 1 so the index wraps
      wr(RD_CIDX, 8'h01);
      for (i = 0; i < 12; i++) begin
         v = 8'($urandom);
         ccol[(i / 3 + 1) % 4][i % 3] = v;
         wr(RD_CDATA, v);
      end
      wr(RD_CIDX, 8'h04);
      for (i = 0; i < 12; i++) rd(RD_CDATA, 8'(ccol[i / 3][i % 3]));
      for (m = 0; m < 4; m++) begin
         ixw(IX_PCTL, 8'(m + 1));
         for (k = 0; k < 4; k++) begin
            go(1'b0, 1'b0, 4'h0, 8'h00);
            cur_planes_i <= 2'(k);
            under_rgb_i  <= 24'($urandom);
            idle2();
            t = cur_t[m][k];
            chk({7'h00, cur_show_o, cur_rgb_o}, {7'h00, t != -1,
                (t == -1) ? under_rgb_i : (t == -2) ? ~under_rgb_i :
                {8'(ccol[t & 3][0]), 8'(ccol[t & 3][1]),
                8'(ccol[t & 3][2])}});
         end
      end
      // Cursor RAM across the top of its space, carrying into control
      ixw(IX_PCTL, 8'h0f);
      wr(RD_WIDX, 8'hfe);
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom);
         cram[(1022 + i) % 1024] = v;
         wr(RD_CRAM, v);
      end
      ixr(IX_PCTL, 8'h03);
      ixw(IX_PCTL, 8'h0f);
      wr(RD_WIDX, 8'hfe);
      for (i = 0; i < 4; i++) rd(RD_CRAM, 8'(cram[(1022 + i) % 1024]));
      // Cursor position and the derived origin
      px = 16'($urandom);
      py = 16'($urandom);
      wr(RD_XLO, px[7:0]);
      wr(RD_XHI, px[15:8]);
      wr(RD_YLO, py[7:0]);
      wr(RD_YHI, py[15:8]);
      idle2();
      chk({cur_pos_x_o, cur_pos_y_o}, {px, py});
      chk({cur_org_x_o, cur_org_y_o}, {px - POS_OFFSET, py - POS_OFFSET});
      rd(RD_XHI, px[15:8]);
      idle2();
      report_and_stop();
   end
endmodule : tb
